// *** verilog/ringer_pkg.sv ***
// constants, types and tone tables of the tone ringer core
package ringer_pkg;

    // ==========================================================
    // timing base
    // ==========================================================
    localparam int OSC_HZ = 32000;
    localparam int BAND_LOW_HZ = 14;
    localparam int BAND_HIGH_HZ = 66;
    localparam int SWEEP_SLOW_HZ = 10;
    localparam int SWEEP_FAST_HZ = 20;

    localparam int PER_W = 12;
    localparam int HALF_W = 7;
    localparam int SWEEP_W = 12;
    localparam int IDX_W = 2;

    // longest accepted ring period rounds down, shortest rounds up
    localparam logic [PER_W-1:0] PER_MAX = PER_W'(OSC_HZ / BAND_LOW_HZ);
    localparam logic [PER_W-1:0] PER_MIN =
        PER_W'((OSC_HZ + BAND_HIGH_HZ - 1) / BAND_HIGH_HZ);
    localparam logic [PER_W-1:0] PER_SAT = {PER_W{1'b1}};
    localparam logic [PER_W-1:0] PER_ONE = PER_W'(1);

    localparam logic [SWEEP_W-1:0] SWEEP_SLOW_LEN =
        SWEEP_W'(OSC_HZ / SWEEP_SLOW_HZ);
    localparam logic [SWEEP_W-1:0] SWEEP_FAST_LEN =
        SWEEP_W'(OSC_HZ / SWEEP_FAST_HZ);
    localparam logic [SWEEP_W-1:0] SWEEP_ONE = SWEEP_W'(1);

    localparam logic [IDX_W-1:0] IDX_FIRST = 2'h0;
    localparam logic [IDX_W-1:0] IDX_ONE = 2'h1;
    localparam logic [IDX_W-1:0] IDX_LAST2 = 2'h1;
    localparam logic [IDX_W-1:0] IDX_LAST3 = 2'h2;
    localparam logic [HALF_W-1:0] HALF_ONE = HALF_W'(1);

    // ==========================================================
    // tone select codes (a is the msb)
    // ==========================================================
    localparam logic [2:0] SEL_LOW3 = 3'h0;
    localparam logic [2:0] SEL_DEEP3 = 3'h1;
    localparam logic [2:0] SEL_HIGH3 = 3'h2;
    localparam logic [2:0] SEL_MID3 = 3'h3;
    localparam logic [2:0] SEL_HIGH2 = 3'h4;
    localparam logic [2:0] SEL_MID2 = 3'h5;
    localparam logic [2:0] SEL_TOP2 = 3'h6;
    localparam logic [2:0] SEL_LOW2 = 3'h7;

    typedef struct packed {
        logic three;
        logic [2:0][HALF_W-1:0] half;
    } tone_cfg_t;

    typedef enum logic {ST_IDLE, ST_RING} ring_state_t;

    // half period in oscillator ticks, rounded to nearest
    function automatic logic [HALF_W-1:0] half_of(input int hz);
        half_of = HALF_W'((OSC_HZ / 2 + hz / 2) / hz);
    endfunction

    function automatic tone_cfg_t mk3(input int f0, input int f1,
                                      input int f2);
        mk3.three = 1'b1;
        mk3.half = {half_of(f2), half_of(f1), half_of(f0)};
    endfunction

    function automatic tone_cfg_t mk2(input int f0, input int f1);
        mk2.three = 1'b0;
        mk2.half = {half_of(f1), half_of(f1), half_of(f0)};
    endfunction

    function automatic tone_cfg_t decode_tones(input logic [2:0] sel);
        if (sel == SEL_DEEP3) decode_tones = mk3(233, 382, 446);
        else if (sel == SEL_HIGH3) decode_tones = mk3(800, 1066, 1333);
        else if (sel == SEL_MID3) decode_tones = mk3(400, 533, 666);
        else if (sel == SEL_LOW3) decode_tones = mk3(466, 764, 892);
        else if (sel == SEL_HIGH2) decode_tones = mk2(1000, 1250);
        else if (sel == SEL_TOP2) decode_tones = mk2(1172, 1333);
        else if (sel == SEL_MID2) decode_tones = mk2(500, 625);
        else decode_tones = mk2(586, 666);
    endfunction

endpackage

// *** verilog/tone_square_gen.sv ***
// square wave generator with complementary outputs
module tone_square_gen import ringer_pkg::*; (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic tick_i,
    input wire logic run_i,
    input wire logic [HALF_W-1:0] half_i,
    output logic wave_pos_o,
    output logic wave_neg_o
);

    logic [HALF_W-1:0] half_cnt;
    logic half_done;

    assign half_done = (half_cnt >= half_i - HALF_ONE);

    // ==========================================================
    // half period counter
    // ==========================================================
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            half_cnt <= '0;
            wave_pos_o <= 1'b0;
            wave_neg_o <= 1'b1;
        end else if (!run_i) begin
            half_cnt <= '0;
            wave_pos_o <= 1'b0;
            wave_neg_o <= 1'b1;
        end else if (tick_i) begin
            if (half_done) begin // [R5]
                half_cnt <= '0;
                wave_pos_o <= ~wave_pos_o; // [R6]
                wave_neg_o <= wave_pos_o;
            end else begin
                half_cnt <= half_cnt + HALF_ONE;
            end
        end
    end

    a_toggle_on_tick: assert property ( // [R7]
        @(posedge clk_i) disable iff (rst_i)
        run_i && $past(run_i) && $changed(wave_pos_o) |-> $past(tick_i))
        else $error("tone toggled without oscillator tick");

endmodule // tone_square_gen

// *** verilog/tone_ringer_sequencer.sv ***
// tone ringer core: ring band check, tone sequencer, bridge drive
//
// Behaviour
// R1: tones only while ring frequency 14..66 Hz
// R2: codes 000..011 pick three-tone sequences
// R3: codes 100..111 pick two-tone sequences
// R4: sweep select low 10 Hz, high 20 Hz
// R5: each tone a 50% duty square wave
// R6: two tone outputs always complementary
// R7: all timing divided from 32 kHz oscillator
// R8: start at first tone, advance per sweep
module tone_ringer_sequencer import ringer_pkg::*; (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic main_osc_i,
    input wire logic ring_line_in_i,
    input wire logic [2:0] tone_sel_i,
    input wire logic sweep_fast_i,
    output logic bell_drive_pos_o,
    output logic bell_drive_neg_o,
    output logic ring_detect_o
);

    // ==========================================================
    // oscillator and ring edges
    // ==========================================================
    logic osc_q;
    logic ring_q;
    logic osc_tick;
    logic ring_rise;
    logic [PER_W-1:0] per_cnt;
    logic per_ok;
    logic per_long;

    assign osc_tick = main_osc_i & ~osc_q; // [R7]
    assign ring_rise = osc_tick & ring_line_in_i & ~ring_q;
    assign per_ok = (per_cnt >= PER_MIN) && (per_cnt <= PER_MAX);
    assign per_long = (per_cnt > PER_MAX);

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            osc_q <= 1'b0;
        end else begin
            osc_q <= main_osc_i;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ring_q <= 1'b0;
        end else if (osc_tick) begin
            ring_q <= ring_line_in_i;
        end
    end

    // ==========================================================
    // ring period measurement
    // ==========================================================
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            per_cnt <= PER_SAT;
        end else if (ring_rise) begin
            per_cnt <= PER_ONE;
        end else if (osc_tick && per_cnt != PER_SAT) begin
            per_cnt <= per_cnt + PER_ONE;
        end
    end

    // in band only after two edges spaced within the band
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ring_detect_o <= 1'b0;
        end else if (ring_rise) begin
            ring_detect_o <= per_ok; // [R1]
        end else if (osc_tick && per_long) begin
            ring_detect_o <= 1'b0; // [R1]
        end
    end

    // ==========================================================
    // sequencer
    // ==========================================================
    ring_state_t state;
    ring_state_t next_state;
    tone_cfg_t cfg;
    logic [SWEEP_W-1:0] sweep_cnt;
    logic [SWEEP_W-1:0] sweep_len;
    logic [IDX_W-1:0] tone_idx;
    logic [IDX_W-1:0] last_idx;
    logic [IDX_W-1:0] next_idx;
    logic step;
    logic tone_run;
    logic [HALF_W-1:0] tone_half;

    assign cfg = decode_tones(tone_sel_i); // [R2] [R3]
    assign sweep_len = sweep_fast_i ? SWEEP_FAST_LEN : SWEEP_SLOW_LEN; // [R4]
    assign last_idx = cfg.three ? IDX_LAST3 : IDX_LAST2;
    assign next_idx = (tone_idx >= last_idx) ? IDX_FIRST
                                             : tone_idx + IDX_ONE;
    assign step = (state == ST_RING) && osc_tick
                  && (sweep_cnt >= sweep_len - SWEEP_ONE);
    assign tone_run = (state == ST_RING);
    assign tone_half = cfg.half[tone_idx];

    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (ring_detect_o) begin
                    next_state = ST_RING;
                end
            end
            ST_RING: begin
                if (!ring_detect_o) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sweep_cnt <= '0;
            tone_idx <= IDX_FIRST;
        end else if (state != ST_RING) begin
            sweep_cnt <= '0;
            tone_idx <= IDX_FIRST; // [R8]
        end else if (step) begin
            sweep_cnt <= '0;
            tone_idx <= next_idx; // [R8]
        end else if (osc_tick) begin
            sweep_cnt <= sweep_cnt + SWEEP_ONE; // [R4]
        end
    end

    // ==========================================================
    // bridge drive
    // ==========================================================
    tone_square_gen u_gen (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick_i(osc_tick),
        .run_i(tone_run),
        .half_i(tone_half),
        .wave_pos_o(bell_drive_pos_o),
        .wave_neg_o(bell_drive_neg_o)
    );

    // ==========================================================
    // checks
    // ==========================================================
    a_drive_complement: assert property ( // [R6]
        @(posedge clk_i) disable iff (rst_i)
        bell_drive_pos_o != bell_drive_neg_o)
        else $error("bridge outputs not complementary");

    a_silent_out_band: assert property ( // [R1]
        @(posedge clk_i) disable iff (rst_i)
        !ring_detect_o |=> ##1 !bell_drive_pos_o)
        else $error("tone output active outside ring band");

    a_band_accept: assert property ( // [R1]
        @(posedge clk_i) disable iff (rst_i)
        ring_rise && per_cnt >= PER_MIN && per_cnt <= PER_MAX
        |=> ring_detect_o ##1 (state == ST_RING))
        else $error("in-band ring not accepted");

    a_band_too_fast: assert property ( // [R1]
        @(posedge clk_i) disable iff (rst_i)
        ring_rise && per_cnt < PER_MIN |=> !ring_detect_o)
        else $error("ring above band accepted");

    a_band_too_slow: assert property ( // [R1]
        @(posedge clk_i) disable iff (rst_i)
        osc_tick && per_cnt > PER_MAX |=> !ring_detect_o)
        else $error("ring below band kept active");

    a_period_restart: assert property ( // [R1]
        @(posedge clk_i) disable iff (rst_i)
        ring_rise |=> per_cnt == PER_ONE)
        else $error("ring period count not restarted");

    a_run_follows: assert property ( // [R1]
        @(posedge clk_i) disable iff (rst_i)
        $changed(ring_detect_o) |=> tone_run == $past(ring_detect_o))
        else $error("tone enable does not follow ring detect");

    a_idle_quiet: assert property ( // [R1]
        @(posedge clk_i) disable iff (rst_i)
        !tone_run |=> !bell_drive_pos_o && bell_drive_neg_o)
        else $error("bridge not at rest while idle");

    a_start_first: assert property ( // [R8]
        @(posedge clk_i) disable iff (rst_i)
        $rose(tone_run) |-> tone_idx == IDX_FIRST && sweep_cnt == '0)
        else $error("sequence did not start at first tone");

    a_three_wrap: assert property ( // [R2]
        @(posedge clk_i) disable iff (rst_i)
        step && cfg.three && tone_idx == IDX_LAST3 |=> tone_idx == IDX_FIRST)
        else $error("three-tone sequence did not wrap");

    a_two_wrap: assert property ( // [R3]
        @(posedge clk_i) disable iff (rst_i)
        step && !cfg.three && tone_idx == IDX_LAST2 |=> tone_idx == IDX_FIRST)
        else $error("two-tone sequence did not wrap");

    a_sweep_hold: assert property ( // [R4]
        @(posedge clk_i) disable iff (rst_i)
        tone_run && !step && $past(tone_run)
        |=> $stable(tone_idx) || !tone_run)
        else $error("tone advanced before sweep period end");

    a_step_only: assert property ( // [R4]
        @(posedge clk_i) disable iff (rst_i)
        tone_run && $past(tone_run) && $changed(tone_idx) |-> $past(step))
        else $error("tone index moved without sweep step");

endmodule // tone_ringer_sequencer

// *** tb/ring_line_model.sv ***
// ring line and oscillator stand-in for the tone ringer bench
module ring_line_model (
    input wire logic clk_i,
    input wire logic [11:0] period_i,
    output logic osc_o,
    output logic ring_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================
    // oscillator and ring edges
    // ==========================================
    logic [11:0] cnt = 12'h000;

    initial osc_o = 1'b0;
    initial ring_o = 1'b0;

    // oscillator at half the clock rate keeps the run short
    // period zero: no ringing, line rests low
    always @(posedge clk_i) begin
        osc_o <= ~osc_o;
        if (!osc_o) begin
            cnt <= cnt + 12'h001;
            if (period_i == 12'h000) begin
                ring_o <= 1'b0;
            end else if (cnt >= period_i - 12'h001) begin
                cnt <= 12'h000;
                ring_o <= 1'b1;
            end else if (cnt == (period_i >> 1)) begin
                ring_o <= 1'b0;
            end
        end
    end
endmodule // ring_line_model

// *** tb/tone_ringer_sequencer_tb_top.sv ***
// self-checking bench of the tone ringer core
module tone_ringer_sequencer_tb_top import ringer_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================
    // stimulus and wiring
    // ==========================================
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [2:0] sel = 3'h0;
    logic fast = 1'b0;
    logic [11:0] period = 12'h280;
    logic osc, ring, pos, neg, det;
    logic [2:0] mon;
    int fails = 0;
    int checked = 0;
    int fa[8] = '{466, 233, 800, 400, 1000, 500, 1172, 586};

    assign mon = {pos, det, ring};

    initial begin
        forever #2 clk = ~clk;
    end

    ring_line_model u_ring_line_model (.clk_i(clk), .period_i(period),
        .osc_o(osc), .ring_o(ring));

    tone_ringer_sequencer u_tone_ringer_sequencer (.clk_i(clk),
        .rst_i(rst), .main_osc_i(osc), .ring_line_in_i(ring),
        .tone_sel_i(sel), .sweep_fast_i(fast), .bell_drive_pos_o(pos),
        .bell_drive_neg_o(neg), .ring_detect_o(det));

    // ==========================================
    // helpers
    // ==========================================
    task automatic tally_and_finish();
        $display("fails=%0d checked=%0d", fails, checked);
        if (fails == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(string name, int exp, int got);
        checked++;
        if (exp != got) begin
            fails++;
            $display("BAD %s expected %0d seen %0d", name, exp, got);
        end
    endtask

    // half period in oscillator ticks, rounded
    function automatic int hf(int hz);
        return (OSC_HZ / 2 + hz / 2) / hz;
    endfunction

    // count clocks until monitored bit k equals v
    task automatic wt(int k, logic v, int lim, output int n);
        n = 0;
        while (mon[k] !== v) begin
            @(posedge clk);
            #1;
            n++;
            if (n > lim) begin
                fails++;
                $display("BAD wait %0d expected %0d seen %0d", k, v, mon[k]);
                tally_and_finish();
            end
        end
    endtask

    task automatic meas(output int hi, output int lo);
        int n;
        wt(2, 1'b0, 400, n);
        wt(2, 1'b1, 400, n);
        wt(2, 1'b0, 400, hi);
        wt(2, 1'b1, 400, lo);
        chk("complement", 1, neg === ~pos);
    endtask

    // one short ring period drops detect, then normal ringing resumes
    task automatic restart();
        int n;
        wt(0, 1'b0, 1400, n);
        wt(0, 1'b1, 1400, n);
        @(posedge clk);
        period <= 12'h12C;
        wt(1, 1'b0, 700, n);
        chk("fast drop", 1, n > 580 && n < 620);
        repeat (3) @(posedge clk);
        #1;
        chk("idle out", 1, pos === 1'b0 && neg === 1'b1);
        @(posedge clk);
        period <= 12'h280;
        wt(1, 1'b1, 1400, n);
    endtask

    // ==========================================
    // scenarios
    // ==========================================
    task automatic t_tone(logic [2:0] s);
        int n, hi, lo, h;
        h = hf(fa[s]);
        @(posedge clk);
        sel <= s;
        restart();
        wt(2, 1'b1, 400, n);
        chk("first rise", 1, n >= 2 * h - 4 && n <= 2 * h + 4);
        meas(hi, lo);
        chk("high time", 2 * h, hi);
        chk("low time", 2 * h, lo);
    endtask

    task automatic t_sweep(logic [2:0] s, logic f, int sw, int a, int b,
                           int c);
        int hi, lo;
        int e[3];
        e = '{a, b, c};
        @(posedge clk);
        sel <= s;
        fast <= f;
        restart();
        repeat (400) @(posedge clk);
        for (int k = 0; k < 3; k++) begin
            repeat (2 * sw) @(posedge clk);
            meas(hi, lo);
            chk("swept tone", 2 * e[k], hi);
            chk("swept low", 2 * e[k], lo);
        end
    endtask

    task automatic t_stop();
        int n;
        wt(0, 1'b0, 1400, n);
        wt(0, 1'b1, 1400, n);
        @(posedge clk);
        period <= 12'h000;
        wt(1, 1'b0, 4800, n);
        chk("slow drop", 1, n > 4550 && n < 4600);
        repeat (3) @(posedge clk);
        #1;
        chk("idle neg", 1, neg === 1'b1 && pos === 1'b0);
    endtask

    initial begin
        int n;
        repeat (5) @(posedge clk);
        #1;
        chk("reset bridge", 1, pos === 1'b0 && neg === 1'b1);
        chk("reset detect", 1, det === 1'b0);
        @(posedge clk);
        rst <= 1'b0;
        wt(1, 1'b1, 4000, n);
        for (int s = 0; s < 8; s++) begin
            t_tone(3'(s));
        end
        t_sweep(3'h2, 1'b1, 1600, hf(1066), hf(1333), hf(800));
        t_sweep(3'h4, 1'b0, 3200, hf(1250), hf(1000), hf(1250));
        t_stop();
        tally_and_finish();
    end
endmodule // tone_ringer_sequencer_tb_top
